// ===== sadc_pkg.sv
package sadc_pkg;

   // clock and conversion timing
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned T_CONV_NS     = 3000;
   localparam int unsigned CONV_CYCLES   = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0]  CONV_CNT_LOAD = 8'(CONV_CYCLES - 1);

   // serial word layout
   localparam int unsigned RESULT_W      = 16;
   localparam logic [4:0]  WORD_EDGES    = 5'h10;
   localparam logic [4:0]  BUSY_EDGES    = 5'h11;

   // reset values
   localparam logic [15:0] RESULT_RST    = 16'h0000;
   localparam logic [7:0]  CNT_RST       = 8'h00;
   localparam logic [4:0]  EDGE_RST      = 5'h00;

   // pin vector positions in the synchroniser
   localparam int unsigned PIN_CS        = 0;
   localparam int unsigned PIN_SI        = 1;
   localparam int unsigned PIN_SCK       = 2;

   typedef enum logic [2:0] {
      SADC_IDLE = 3'b001,
      SADC_CONV = 3'b010,
      SADC_ACQ  = 3'b100
   } sadc_state_t;

   // interface style held between convert_start rises; busy option also reloaded at conversion end in chip-select mode
   typedef struct packed {
      logic daisy;
      logic busy_en;
   } sadc_mode_t;

   // status handed from the serial clock side to the system side
   typedef struct packed {
      logic started;
      logic done;
      logic data;
   } sadc_link_t;

endpackage : sadc_pkg

// ===== sadc_readout.sv
`timescale 1ns/1ps

// Behaviour
// - serial_in high at start selects chip-select
// - start rise: output hi-Z in chip-select mode, sample, convert
// - convert_start held high until readout ends
// - serial_in low at end gives busy
// - conversion end: acquire, power down, drive busy
// - MSB on first falling edge, then lower
// - hi-Z after 16th edge (17th with busy) or serial_in high
// - serial_in low at start selects daisy-chain
// - daisy-chain start drives serial_out low
// - serial clock level at start picks busy
// - conversion continues whatever serial clock does
// - no busy: MSB first at end, shift
// - capture serial_in on every falling edge but the first with busy
// - forward upstream word right after own word
// - grounded first device low after 16 edges
// - busy: busy bit, then result next edge
// - tied first device high after 17 edges
// - simultaneous rise still selects daisy-chain
// - busy is one bit before the word
module sadc_readout
   import sadc_pkg::*;
(
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                serial_clk_i,
   input  wire logic                convert_start_i,
   input  wire logic                serial_in_i,
   input  wire logic [RESULT_W-1:0] conv_data_i,
   output logic                     serial_out_o,
   output logic                     serial_oe_o,
   output logic                     converting_o,
   output logic                     power_down_o
);

   // system clock side
   logic [2:0]          pin_s1_reg;
   logic [2:0]          pin_s2_reg;
   logic [2:0]          pin_s3_reg;
   logic                cs_rise;
   sadc_state_t         state_reg;
   logic [7:0]          conv_cnt_reg;
   sadc_mode_t          mode_reg;
   logic [RESULT_W-1:0] result_reg;
   logic                frame_clr_reg;
   sadc_link_t          lnk_s1_reg;
   sadc_link_t          lnk_s2_reg;
   logic                out_reg;
   logic                oe_reg;
   logic                conv_reg;
   logic                pdn_reg;

   // serial clock side
   logic                lrst;
   logic [4:0]          edge_reg;
   logic [RESULT_W-1:0] shift_reg;
   logic [RESULT_W-1:0] shift_next;
   logic                started_reg;
   logic                done_reg;
   sadc_link_t          lnk_stat;

   // pins come from the host, so two stages before use
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pin_s1_reg <= 3'h0;
         pin_s2_reg <= 3'h0;
         pin_s3_reg <= 3'h0;
      end else begin
         pin_s1_reg <= {serial_clk_i, serial_in_i, convert_start_i};
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
      end
   end

   assign cs_rise = pin_s2_reg[PIN_CS] & ~pin_s3_reg[PIN_CS];

   // conversion sequencer on the internal clock
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg    <= SADC_IDLE;
         conv_cnt_reg <= CNT_RST;
      end else begin
         case (state_reg)
            SADC_IDLE, SADC_ACQ: begin
               if (cs_rise) begin
                  state_reg    <= SADC_CONV;
                  conv_cnt_reg <= CONV_CNT_LOAD;
               end
            end
            SADC_CONV: begin
               // no pin is looked at until the count runs out
               if (conv_cnt_reg == CNT_RST) begin
                  state_reg <= SADC_ACQ;
               end else begin
                  conv_cnt_reg <= conv_cnt_reg - 8'h01;
               end
            end
            default: begin
               state_reg <= SADC_IDLE;
            end
         endcase
      end
   end

   // mode capture; serial_in taken one sample early so a
   // simultaneous rise still reads low
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_reg <= '0;
      end else if (cs_rise && state_reg != SADC_CONV) begin
         mode_reg.daisy   <= ~pin_s3_reg[PIN_SI];
         mode_reg.busy_en <= pin_s2_reg[PIN_SCK];
      end else if (state_reg == SADC_CONV && conv_cnt_reg == CNT_RST && !mode_reg.daisy) begin
         mode_reg.busy_en <= ~pin_s2_reg[PIN_SI];
      end
   end

   // result word stays still for the whole readout
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         result_reg <= RESULT_RST;
      end else if (state_reg == SADC_CONV && conv_cnt_reg == CNT_RST) begin
         result_reg <= conv_data_i;
      end
   end

   // clears the serial side; the serial clock is expected idle here
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         frame_clr_reg <= 1'b0;
      end else begin
         frame_clr_reg <= cs_rise && state_reg != SADC_CONV;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         lnk_s1_reg <= '0;
         lnk_s2_reg <= '0;
      end else begin
         lnk_s1_reg <= lnk_stat;
         lnk_s2_reg <= lnk_s1_reg;
      end
   end

   // pin drive; data follows the serial side three clocks late,
   // inside half a serial clock period
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_reg <= 1'b0;
         oe_reg  <= 1'b0;
      end else if (cs_rise && state_reg != SADC_CONV) begin
         out_reg <= 1'b0;
         oe_reg  <= ~pin_s3_reg[PIN_SI];
      end else if (state_reg == SADC_ACQ) begin
         if (lnk_s2_reg.started) begin
            out_reg <= lnk_s2_reg.data;
         end else begin
            out_reg <= mode_reg.busy_en ? 1'b0 : result_reg[RESULT_W-1];
         end
         if (!mode_reg.daisy) begin
            oe_reg <= ~pin_s2_reg[PIN_SI] & ~lnk_s2_reg.done;
         end
      end else if (state_reg == SADC_CONV) begin
         out_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         conv_reg <= 1'b0;
         pdn_reg  <= 1'b0;
      end else begin
         conv_reg <= state_reg == SADC_CONV;
         pdn_reg  <= state_reg == SADC_ACQ;
      end
   end

   assign serial_out_o = out_reg;
   assign serial_oe_o  = oe_reg;
   assign converting_o = conv_reg;
   assign power_down_o = pdn_reg;

   // serial clock side, cleared at each conversion start;
   // mode and result are read only once they have settled
   assign lrst = rst_i | frame_clr_reg;

   always_comb begin
      if (edge_reg == EDGE_RST) begin
         shift_next = mode_reg.busy_en ? result_reg
                                       : {result_reg[RESULT_W-2:0], serial_in_i};
      end else begin
         shift_next = {shift_reg[RESULT_W-2:0], serial_in_i};
      end
   end

   always_ff @(negedge serial_clk_i or posedge lrst) begin
      if (lrst) begin
         edge_reg    <= EDGE_RST;
         shift_reg   <= RESULT_RST;
         started_reg <= 1'b0;
         done_reg    <= 1'b0;
      end else begin
         if (edge_reg != BUSY_EDGES) begin
            edge_reg <= edge_reg + 5'h01;
         end
         shift_reg   <= shift_next;
         started_reg <= 1'b1;
         // busy adds one edge before the word ends
         done_reg    <= (edge_reg + 5'h01) >=
                        (mode_reg.busy_en ? BUSY_EDGES : WORD_EDGES);
      end
   end

   assign lnk_stat = '{started: started_reg, done: done_reg, data: shift_reg[RESULT_W-1]};

endmodule : sadc_readout

// ===== sadc_readout_asserts.sv
`timescale 1ns/1ps
module sadc_readout_asserts
   import sadc_pkg::*;
(
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire logic                serial_clk_i,
   input wire logic                convert_start_i,
   input wire logic                serial_in_i,
   input wire logic [RESULT_W-1:0] conv_data_i,
   input wire logic                serial_out_o,
   input wire logic                serial_oe_o,
   input wire logic                converting_o,
   input wire logic                power_down_o
);
   localparam logic [7:0] CONV_N = 8'(CONV_CYCLES);
   logic [7:0] conv_cnt_reg;
   logic [7:0] age_reg;
   logic       sck_reg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         conv_cnt_reg <= 8'h00;
      end else begin
         conv_cnt_reg <= converting_o ? conv_cnt_reg + 8'h01 : 8'h00;
      end
   end
   // age since a serial clock fall, saturating so idle time never wraps
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sck_reg <= 1'b0;
         age_reg <= 8'hFF;
      end else begin
         sck_reg <= serial_clk_i;
         age_reg <= (sck_reg && !serial_clk_i) ? 8'h00 : age_reg + {7'h00, age_reg != 8'hFF};
      end
   end
   a_conv_length: assert property ($fell(converting_o) |-> conv_cnt_reg == CONV_N)
      else $error("conversion length wrong");
   a_acq_after: assert property ($fell(converting_o) |-> power_down_o)
      else $error("no power down after conversion");
   a_pd_excl: assert property (power_down_o |-> !converting_o)
      else $error("power down while converting");
   a_conv_quiet: assert property (converting_o |-> !(serial_oe_o && serial_out_o))
      else $error("output driven high during conversion");
   a_oe_conv_stable: assert property (converting_o && $past(converting_o) |-> $stable(serial_oe_o))
      else $error("output enable moved during conversion");
   a_start_cause: assert property ($rose(converting_o) |-> convert_start_i && $past(convert_start_i, 2))
      else $error("conversion without start");
   a_pd_exit: assert property ($fell(power_down_o) |-> ##[0:1] converting_o)
      else $error("left acquisition without start");
   a_bit_timing: assert property ($changed(serial_out_o) && serial_oe_o && $past(serial_oe_o)
      && $past(power_down_o, 4) |-> age_reg <= 8'h06)
      else $error("serial bit changed away from clock edge");
endmodule : sadc_readout_asserts

bind sadc_readout sadc_readout_asserts sadc_readout_asserts_inst (
   .clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(serial_clk_i),
   .convert_start_i(convert_start_i), .serial_in_i(serial_in_i), .conv_data_i(conv_data_i),
   .serial_out_o(serial_out_o), .serial_oe_o(serial_oe_o), .converting_o(converting_o),
   .power_down_o(power_down_o));

// ===== sadc_host_model.sv
`timescale 1ns/1ps
module sadc_host_model (
   input  wire logic serial_out_i,
   input  wire logic serial_oe_i,
   output logic      convert_start_o,
   output logic      serial_in_o,
   output logic      serial_clk_o
);
   logic wire_lvl;
   // pull-up holds the released line high
   assign wire_lvl = serial_oe_i ? serial_out_i : 1'b1;
   initial begin
      convert_start_o = 1'b0;
      serial_in_o = 1'b1;
      serial_clk_o = 1'b0;
   end
   task automatic frame(input logic daisy, input logic busy, input logic [15:0] up,
                        input int edges, output logic [33:0] got);
      logic [15:0] sh;
      sh = up;
      got = '0;
      serial_in_o = !daisy;
      serial_clk_o = daisy && busy;
      #200;
      convert_start_o = 1'b1;
      if (daisy && busy) serial_in_o = 1'b1;
      #1000;
      if (!daisy) serial_in_o = 1'b0;
      #3000;
      // clock only runs inside the readout, 160 ns period
      for (int i = 0; i <= edges; i++) begin
         serial_clk_o = 1'b1;
         #80;
         got = {got[32:0], wire_lvl};
         if (i == edges) break;
         if (daisy && !busy) serial_in_o = sh[15];
         sh = {sh[14:0], 1'b0};
         serial_clk_o = 1'b0;
         #80;
      end
      serial_in_o = 1'b1;
      #200;
      convert_start_o = 1'b0;
      #200;
   endtask : frame
endmodule : sadc_host_model

// ===== sadc_readout_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; $display("Error %0t ns: word %h expected %h", $time, g, e); end end
module sadc_readout_test
   import sadc_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [RESULT_W-1:0] conv_data_i = '0;
   logic serial_out_o, serial_oe_o, converting_o, power_down_o, cs, si, sck;
   logic daisy, busy;
   logic [15:0] res, up;
   logic [33:0] got;
   int fails = 0;
   int checks_done = 0;
   int cycles = 0;
   always #12.5 clk_i = ~clk_i;
   sadc_readout sadc_readout_inst (.clk_i(clk_i), .rst_i(rst_i), .serial_clk_i(sck),
      .convert_start_i(cs), .serial_in_i(si), .conv_data_i(conv_data_i),
      .serial_out_o(serial_out_o), .serial_oe_o(serial_oe_o), .converting_o(converting_o),
      .power_down_o(power_down_o));
   sadc_host_model sadc_host_model_inst (.serial_out_i(serial_out_o), .serial_oe_i(serial_oe_o),
      .convert_start_o(cs), .serial_in_o(si), .serial_clk_o(sck));
   function automatic logic [33:0] exp_word(input logic d, input logic b,
                                            input logic [15:0] r, input logic [15:0] u);
      if (d && !b) return {1'b0, r, u, 1'b0};
      return {17'h0, r, 1'b1};
   endfunction : exp_word
   task automatic tally_and_finish;
      if (fails == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         fails++;
         tally_and_finish();
      end
   end
   initial begin
      void'($urandom(64));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      // extremes first, then random words in every mode but chip-select without busy
      for (int n = 0; n < 24; n++) begin
         res = (n < 3) ? 16'hFFFF : (n < 6) ? 16'h0000 : 16'($urandom);
         up = 16'($urandom);
         daisy = (n % 3) != 0;
         busy = (n % 3) != 1;
         @(posedge clk_i);
         conv_data_i <= res;
         sadc_host_model_inst.frame(daisy, busy, up, (daisy && !busy) ? 32 : 17, got);
         `CHK(got, exp_word(daisy, busy, res, up))
      end
      tally_and_finish();
   end
endmodule : sadc_readout_test
